// ===== fpwm_fan_ctrl.sv
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1: PWM period is 2 x frequency setting steps of selected clock; full duty equals that.
// RULE2: Direct mode duty equals PWM value over full-duty value.
// RULE3: Fan config register holds tach bits, clock select and output polarity.
// RULE4: Host writes fan config, then spin-up, then frequency before other fan registers.
// RULE5: Spin-up settings live in bits 0 to 5 of the spin-up register.
// RULE6: Frequency setting is bits 0 to 4 and works with the clock select.
// RULE7: Host writes either the lookup table or the direct PWM value, not both.
// RULE8: After writing the table, host clears fan config bit 5 to hand over.
// RULE9: Every register accepts writes at any time; no ordering is enforced.
// RULE10: Tach period is counted in 90 kHz clock periods.
// RULE11: The 16-bit tach count reads as low byte then high byte.
// RULE12: Software computes speed as factor times 5,400,000 over the count.
// RULE13: Eight temperature and PWM pairs map remote temperature to duty.
// RULE14: A frequency setting of zero acts as one.
module fpwm_fan_ctrl (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic [9:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output var  logic [31:0] avs_readdata_o,
  output var  logic        avs_waitrequest_o,
  input  wire logic [7:0]  remote_temp_i,
  input  wire logic        tach_i,
  output var  logic        pwm_out_o,
  output var  logic        pwm_oe_o
);

  // ==========================================================================
  // Decoding helpers.
  // ==========================================================================
  // Highest step whose temperature the reading has reached wins; below the
  // first step the first step's value still applies, so the fan stops only if that value is zero.
  function automatic logic [5:0] lut_pick(
    input logic [7:0]   temp,
    input logic [127:0] tbl
  );
    logic [5:0] r;
    r = tbl[13:8];
    for (int i = 0; i < 8; i++)
    begin
      if (temp >= tbl[16*i +: 8])
      begin
        r = tbl[16*i + 8 +: 6];
      end
    end
    return r;
  endfunction : lut_pick

  function automatic logic is_lut(input logic [7:0] idx);
    return (idx >= fpwm_pkg::IDX_LUT_FIRST) && (idx <= fpwm_pkg::IDX_LUT_LAST);
  endfunction : is_lut

  // ==========================================================================
  // Rate ticks.
  // ==========================================================================
  logic fast_tick;
  logic slow_tick;
  logic tach_tick;

  fpwm_tick_gen #(.RATE_HZ(fpwm_pkg::PWM_FAST_HZ)) u_fast (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .tick_o    (fast_tick)
  );

  fpwm_tick_gen #(.RATE_HZ(fpwm_pkg::PWM_SLOW_HZ)) u_slow (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .tick_o    (slow_tick)
  );

  fpwm_tick_gen #(.RATE_HZ(fpwm_pkg::TACH_HZ)) u_tach (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .tick_o    (tach_tick)
  );

  // ==========================================================================
  // Register file and Avalon slave.
  // ==========================================================================
  logic [7:0]   fan_cfg_q;
  logic [7:0]   fan_cfg_d;
  logic [5:0]   spin_up_q;
  logic [5:0]   spin_up_d;
  logic [5:0]   pwm_val_q;
  logic [5:0]   pwm_val_d;
  logic [4:0]   pwm_freq_q;
  logic [4:0]   pwm_freq_d;
  logic [127:0] lut_q;
  logic [127:0] lut_d;
  logic         wait_q;
  logic         wait_d;
  logic [31:0]  rdata_q;
  logic [31:0]  rdata_d;
  logic [7:0]   hi_shadow_q;
  logic [7:0]   hi_shadow_d;
  logic [15:0]  tach_count_q;

  logic [7:0]   idx;
  logic         aligned;
  logic         wr_fire;
  logic         rd_first;
  logic [7:0]   wbyte;
  logic [7:0]   rbyte;

  assign idx      = avs_address_i[9:2];
  assign aligned  = (avs_address_i[1:0] == 2'b00);
  assign wbyte    = avs_writedata_i[7:0];
  // A write lands at the edge where the master sees waitrequest low.
  assign wr_fire  = avs_write_i && !wait_q && aligned && avs_byteenable_i[0];
  assign rd_first = avs_read_i && wait_q;

  always_comb
  begin
    rbyte = 8'h00;
    if (aligned)
    begin
      case (idx)
        fpwm_pkg::IDX_TACH_LO:  rbyte = tach_count_q[7:0];           // [RULE11]
        fpwm_pkg::IDX_TACH_HI:  rbyte = hi_shadow_q;                 // [RULE11]
        fpwm_pkg::IDX_FAN_CFG:  rbyte = fan_cfg_q;
        fpwm_pkg::IDX_SPIN_UP:  rbyte = {2'b00, spin_up_q};
        fpwm_pkg::IDX_PWM_VAL:  rbyte = {2'b00, pwm_val_q};
        fpwm_pkg::IDX_PWM_FREQ: rbyte = {3'b000, pwm_freq_q};
        default:
        begin
          if (is_lut(idx))
          begin
            rbyte = lut_q[8*idx[3:0] +: 8];
          end
        end
      endcase
    end
  end

  always_comb
  begin
    fan_cfg_d   = fan_cfg_q;
    spin_up_d   = spin_up_q;
    pwm_val_d   = pwm_val_q;
    pwm_freq_d  = pwm_freq_q;
    lut_d       = lut_q;
    hi_shadow_d = hi_shadow_q;
    rdata_d     = rdata_q;
    wait_d      = !((avs_read_i || avs_write_i) && wait_q);
    if (rd_first)
    begin
      rdata_d = {24'h000000, rbyte};
      // Reading the low byte freezes the high byte, so the pair is coherent.
      if (aligned && (idx == fpwm_pkg::IDX_TACH_LO))
      begin
        hi_shadow_d = tach_count_q[15:8];                            // [RULE11]
      end
    end
    // No write is held back by configuration order.
    if (wr_fire)                                                     // [RULE9]
    begin
      case (idx)
        fpwm_pkg::IDX_FAN_CFG:  fan_cfg_d  = wbyte & fpwm_pkg::FCFG_MASK; // [RULE3]
        fpwm_pkg::IDX_SPIN_UP:  spin_up_d  = wbyte[5:0];                  // [RULE5]
        fpwm_pkg::IDX_PWM_VAL:  pwm_val_d  = wbyte[5:0];
        fpwm_pkg::IDX_PWM_FREQ: pwm_freq_d = wbyte[4:0];                  // [RULE6]
        default:
        begin
          if (is_lut(idx))
          begin
            lut_d[8*idx[3:0] +: 8] = wbyte;                          // [RULE13]
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      fan_cfg_q   <= fpwm_pkg::FAN_CFG_RST;
      spin_up_q   <= fpwm_pkg::SPIN_UP_RST;
      pwm_val_q   <= fpwm_pkg::PWM_VAL_RST;
      pwm_freq_q  <= fpwm_pkg::PWM_FREQ_RST;
      lut_q       <= {fpwm_pkg::LUT_REGS{fpwm_pkg::LUT_RST}};
      hi_shadow_q <= 8'h00;
      rdata_q     <= 32'h00000000;
      wait_q      <= 1'b1;
    end
    else
    begin
      fan_cfg_q   <= fan_cfg_d;
      spin_up_q   <= spin_up_d;
      pwm_val_q   <= pwm_val_d;
      pwm_freq_q  <= pwm_freq_d;
      lut_q       <= lut_d;
      hi_shadow_q <= hi_shadow_d;
      rdata_q     <= rdata_d;
      wait_q      <= wait_d;
    end
  end

  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;

  // ==========================================================================
  // Tachometer period measurement.
  // ==========================================================================
  logic        tach_s1_q;
  logic        tach_s2_q;
  logic        tach_s3_q;
  logic [15:0] run_cnt_q;
  logic [15:0] run_cnt_d;
  logic [15:0] tach_count_d;
  logic        tach_rise;

  assign tach_rise = tach_s2_q && !tach_s3_q;

  // One rising edge to the next is one tach period: a revolution of a
  // two-pulse fan takes two, which the speed formula accounts for.
  always_comb
  begin
    run_cnt_d    = run_cnt_q;
    tach_count_d = tach_count_q;
    if (tach_rise)
    begin
      tach_count_d = run_cnt_q;                                      // [RULE10]
      run_cnt_d    = 16'h0000;
    end
    else if (tach_tick)
    begin
      if (run_cnt_q != fpwm_pkg::TACH_MAX)
      begin
        run_cnt_d = run_cnt_q + 16'h0001;                            // [RULE10]
      end
      else
      begin
        // A stalled fan shows the full count instead of a stale reading.
        tach_count_d = fpwm_pkg::TACH_MAX;
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      tach_s1_q    <= 1'b0;
      tach_s2_q    <= 1'b0;
      tach_s3_q    <= 1'b0;
      run_cnt_q    <= 16'h0000;
      tach_count_q <= fpwm_pkg::TACH_RST;
    end
    else
    begin
      tach_s1_q    <= tach_i;
      tach_s2_q    <= tach_s1_q;
      tach_s3_q    <= tach_s2_q;
      run_cnt_q    <= run_cnt_d;
      tach_count_q <= tach_count_d;
    end
  end

  // ==========================================================================
  // PWM generator.
  // ==========================================================================
  logic [5:0] step_q;
  logic [5:0] step_d;
  logic       oe_q;
  logic       oe_d;
  logic       pwm_tick;
  logic [4:0] freq_eff;
  logic [5:0] full;
  logic [5:0] duty;
  logic       drive_on;
  logic       pin_high;

  assign pwm_tick = fan_cfg_q[fpwm_pkg::FCFG_CLKSEL_BIT] ? fast_tick : slow_tick; // [RULE3]
  assign freq_eff = (pwm_freq_q == 5'h00) ? 5'h01 : pwm_freq_q;                   // [RULE14]
  assign full     = {freq_eff, 1'b0};                                             // [RULE1]
  assign duty     = fan_cfg_q[fpwm_pkg::FCFG_LUTDIS_BIT] ? pwm_val_q              // [RULE2]
                                                         : lut_pick(remote_temp_i, lut_q); // [RULE13]
  // A value at or above full duty keeps the output on for the whole period.
  assign drive_on = (step_q < duty);                                              // [RULE2]
  assign pin_high = fan_cfg_q[fpwm_pkg::FCFG_POL_BIT] ? drive_on : !drive_on;     // [RULE3]

  always_comb
  begin
    step_d = step_q;
    if (pwm_tick)
    begin
      // Lowering the setting mid-period so that the new last step is already reached ends the period at the next tick.
      if (step_q >= full - 6'h01)
      begin
        step_d = 6'h00;                                              // [RULE1]
      end
      else
      begin
        step_d = step_q + 6'h01;
      end
    end
    oe_d = !pin_high;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      step_q <= 6'h00;
      oe_q   <= 1'b0;
    end
    else
    begin
      step_q <= step_d;
      oe_q   <= oe_d;
    end
  end

  // The pin is open drain: it only ever pulls low.
  assign pwm_out_o = 1'b0;
  assign pwm_oe_o  = oe_q;

endmodule : fpwm_fan_ctrl
`default_nettype wire

// ===== fpwm_pkg.sv
`default_nettype none
// ============================================================================
// Shared constants of the fan drive and tachometer block.
// ============================================================================
package fpwm_pkg;

  // ==========================================================================
  // Clock rates.
  // ==========================================================================
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned PWM_FAST_HZ  = 360_000;
  localparam int unsigned PWM_SLOW_HZ  = 1_400;
  localparam int unsigned TACH_HZ      = 90_000;

  // ==========================================================================
  // Register indices; the byte address is four times the index.
  // ==========================================================================
  localparam logic [7:0] IDX_TACH_LO   = 8'h46;
  localparam logic [7:0] IDX_TACH_HI   = 8'h47;
  localparam logic [7:0] IDX_FAN_CFG   = 8'h4a;
  localparam logic [7:0] IDX_SPIN_UP   = 8'h4b;
  localparam logic [7:0] IDX_PWM_VAL   = 8'h4c;
  localparam logic [7:0] IDX_PWM_FREQ  = 8'h4d;
  localparam logic [7:0] IDX_LUT_FIRST = 8'h50;
  localparam logic [7:0] IDX_LUT_LAST  = 8'h5f;

  // ==========================================================================
  // Field layout.
  // ==========================================================================
  localparam int unsigned FCFG_TACH_LSB   = 0;
  localparam int unsigned FCFG_TACH_MSB   = 1;
  localparam int unsigned FCFG_CLKSEL_BIT = 3;
  localparam int unsigned FCFG_POL_BIT    = 4;
  localparam int unsigned FCFG_LUTDIS_BIT = 5;
  localparam logic [7:0]  FCFG_MASK       = 8'h3b;
  localparam int unsigned SPIN_W          = 6;
  localparam int unsigned PWMV_W          = 6;
  localparam int unsigned FREQ_W          = 5;
  localparam int unsigned LUT_STEPS       = 8;
  localparam int unsigned LUT_REGS        = 16;
  localparam int unsigned TACH_W          = 16;
  localparam logic [15:0] TACH_MAX        = 16'hffff;

  // ==========================================================================
  // Reset values.
  // ==========================================================================
  localparam logic [7:0]        FAN_CFG_RST  = 8'h20;
  localparam logic [SPIN_W-1:0] SPIN_UP_RST  = 6'h00;
  localparam logic [PWMV_W-1:0] PWM_VAL_RST  = 6'h00;
  localparam logic [FREQ_W-1:0] PWM_FREQ_RST = 5'h00;
  localparam logic [7:0]        LUT_RST      = 8'h00;
  localparam logic [15:0]       TACH_RST     = 16'hffff;

endpackage : fpwm_pkg
`default_nettype wire

// ===== fpwm_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Fractional rate divider: one-cycle tick at RATE_HZ on average.
// ============================================================================
module fpwm_tick_gen #(
  parameter int unsigned RATE_HZ = fpwm_pkg::TACH_HZ
) (
  input  wire logic ref_clk_i,
  input  wire logic resetn_i,
  output var  logic tick_o
);

  // The rates do not divide the system clock evenly, so a phase accumulator
  // spreads the error; single periods jitter by one clock cycle.
  localparam logic [25:0] INC = 26'(RATE_HZ);
  localparam logic [25:0] LIM = 26'(fpwm_pkg::CLK_HZ);

  logic [25:0] acc_q;
  logic [25:0] acc_d;
  logic        tick_q;
  logic        tick_d;
  logic [25:0] sum;

  always_comb
  begin
    sum = acc_q + INC;
    if (sum >= LIM)
    begin
      acc_d  = sum - LIM;
      tick_d = 1'b1;
    end
    else
    begin
      acc_d  = sum;
      tick_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      acc_q  <= 26'h0;
      tick_q <= 1'b0;
    end
    else
    begin
      acc_q  <= acc_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

endmodule : fpwm_tick_gen
`default_nettype wire

// ===== fpwm_fan_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bus answer and pin checks, seen from the top ports only.
module fpwm_fan_ctrl_sva (
  input wire logic        ref_clk_i,
  input wire logic        resetn_i,
  input wire logic [9:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic [7:0]  remote_temp_i,
  input wire logic        tach_i,
  input wire logic        pwm_out_o,
  input wire logic        pwm_oe_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_ack;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  sequence s_rd(logic [9:0] a);
    avs_read_i && avs_waitrequest_o && avs_address_i == a;
  endsequence
  a_req_one_ack: assert property (s_req |=> s_ack)
    else $error("request not answered in exactly one cycle");
  a_idle_no_ack: assert property (!avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer without a request");
  a_reset_quiet: assert property (disable iff (1'b0) !resetn_i |=> avs_waitrequest_o && avs_readdata_o == 32'h0 && !pwm_oe_o)
    else $error("outputs not quiet after reset");
  a_rdata_holds: assert property (!avs_waitrequest_o |=> $stable(avs_readdata_o))
    else $error("read data changed after the answer");
  a_rdata_byte: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  a_unmapped_zero: assert property (s_rd(10'h120) |=> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_cfg_fields: assert property (s_rd(10'h128) |=> (avs_readdata_o & 32'hc4) == 32'h0)
    else $error("unused configuration bits read as one");
  a_freq_field: assert property (s_rd(10'h134) |=> (avs_readdata_o & 32'he0) == 32'h0)
    else $error("frequency field wider than five bits");
  a_pin_data_low: assert property (pwm_out_o == 1'b0)
    else $error("open-drain data not low");
endmodule : fpwm_fan_ctrl_sva

bind fpwm_fan_ctrl fpwm_fan_ctrl_sva chk_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .remote_temp_i(remote_temp_i), .tach_i(tach_i), .pwm_out_o(pwm_out_o), .pwm_oe_o(pwm_oe_o));
`default_nettype wire

// ===== fpwm_fan_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Fan with a pulled-up drive pin and a tach output.
module fpwm_fan_model #(
  parameter int unsigned TACH_PERIOD = 66667,
  parameter int unsigned TACH_START  = 3000
) (
  input  wire logic ref_clk_i,
  input  wire logic pwm_out_i,
  input  wire logic pwm_oe_i,
  output wire logic tach_o,
  output wire logic pin_o
);
  int unsigned cnt_q  = 0;
  logic        tach_q = 1'b0;
  // The pull-up wins whenever the drive is released.
  assign pin_o  = pwm_oe_i ? pwm_out_i : 1'b1;
  assign tach_o = tach_q;
  always_ff @(posedge ref_clk_i)
  begin
    cnt_q  <= (cnt_q == TACH_START + TACH_PERIOD - 1) ? TACH_START : cnt_q + 1;
    tach_q <= (cnt_q >= TACH_START) && (cnt_q < TACH_START + 100);
  end
endmodule : fpwm_fan_model
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        ref_clk_i = 1'b0;
  logic        resetn_i  = 1'b0;
  logic [9:0]  addr      = 10'h0;
  logic        rd        = 1'b0;
  logic        wr        = 1'b0;
  logic [31:0] wdata     = 32'h0;
  logic [3:0]  be        = 4'hf;
  logic [7:0]  temp      = 8'h0;
  logic [31:0] rdata;
  logic [31:0] got;
  logic        wait_o;
  logic        tach;
  logic        pwm_out;
  logic        pwm_oe;
  logic        pin;
  int          fail_count  = 0;
  int          check_count = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  fpwm_fan_ctrl dut_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o), .remote_temp_i(temp),
    .tach_i(tach), .pwm_out_o(pwm_out), .pwm_oe_o(pwm_oe));
  fpwm_fan_model fan_u (.ref_clk_i(ref_clk_i), .pwm_out_i(pwm_out), .pwm_oe_i(pwm_oe),
    .tach_o(tach), .pin_o(pin));
  // ==========
  // Tasks.
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // The request is held until waitrequest is sampled low, then released.
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge ref_clk_i);
    rd    <= !w;
    wr    <= w;
    addr  <= {idx, 2'b00};
    wdata <= {24'h0, d};
    do
      @(posedge ref_clk_i);
    while (wait_o !== 1'b0);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic rchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    check(name, got, exp);
  endtask : rchk
  // Low time of the pin and its falling edges over a window, after a settling gap.
  task automatic duty(input string name, input int win, input int pct, input int e_lo, input int e_hi);
    int   low;
    int   edges;
    logic prev;
    low   = 0;
    edges = 0;
    repeat (300) @(posedge ref_clk_i);
    prev = pin;
    repeat (win)
    begin
      @(posedge ref_clk_i);
      if (pin === 1'b0) low++;
      if (pin === 1'b0 && prev === 1'b1) edges++;
      prev = pin;
    end
    check(name, {31'h0, low * 100 + 3 * win >= pct * win && low * 100 <= pct * win + 3 * win}, 32'h1);
    check(name, {31'h0, edges >= e_lo && edges <= e_hi}, 32'h1);
  endtask : duty
  // ==========
  // Tests.
  initial
  begin
    int fq [5];
    int pv [5];
    int pc [5];
    int fp;
    int ne;
    fq = '{0, 2, 3, 2, 5};
    pv = '{1, 3, 6, 3, 4};
    pc = '{50, 75, 100, 25, 40};
    repeat (12) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    rchk("fan_config reset", 8'h4a, 32'h20);
    rchk("spin_up reset", 8'h4b, 32'h0);
    rchk("pwm_frequency reset", 8'h4d, 32'h0);
    rchk("pwm_value reset", 8'h4c, 32'h0);
    bus(1'b1, 8'h46, 8'h00);
    rchk("tach low reset", 8'h46, 32'hff);
    rchk("tach high reset", 8'h47, 32'hff);
    bus(1'b1, 8'h48, 8'h55);
    rchk("unmapped", 8'h48, 32'h0);
    bus(1'b1, 8'h4a, 8'hff);
    rchk("fan_config", 8'h4a, 32'h3b);
    bus(1'b1, 8'h4b, 8'hff);
    rchk("spin_up", 8'h4b, 32'h3f);
    bus(1'b1, 8'h4d, 8'hff);
    rchk("pwm_frequency", 8'h4d, 32'h1f);
    be <= 4'he;
    bus(1'b1, 8'h4d, 8'h02);
    be <= 4'hf;
    rchk("byte enable off", 8'h4d, 32'h1f);
    // Direct mode at the fast clock; the polarity case inverts the pin.
    for (int i = 0; i < 5; i++)
    begin
      fp = (fq[i] == 0) ? 1 : fq[i];
      ne = (pc[i] == 100) ? 0 : 54 / fp;
      bus(1'b1, 8'h4a, (i == 3) ? 8'h38 : 8'h28);
      bus(1'b1, 8'h4d, fq[i][7:0]);
      bus(1'b1, 8'h4c, pv[i][7:0]);
      duty("direct duty", 6000, pc[i], (ne > 0) ? ne - 1 : 0, ne + 1);
    end
    bus(1'b1, 8'h4a, 8'h20);
    bus(1'b1, 8'h4d, 8'h01);
    bus(1'b1, 8'h4c, 8'h01);
    duty("slow clock", 30000, 50, 1, 2);
    // Table mode: temperatures 20, 30, .. with values 1 .. 8, full duty 8.
    bus(1'b1, 8'h4a, 8'h28);
    bus(1'b1, 8'h4b, 8'h00);
    bus(1'b1, 8'h4d, 8'h04);
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, 8'h50 + 8'(2 * i), 8'(20 + 10 * i));
      bus(1'b1, 8'h51 + 8'(2 * i), 8'(i + 1));
    end
    bus(1'b1, 8'h4a, 8'h08);
    temp <= 8'd45;
    duty("table mid", 6000, 37, 13, 14);
    temp <= 8'd5;
    duty("table below", 6000, 12, 13, 14);
    temp <= 8'hff;
    duty("table top", 6000, 100, 0, 0);
    // Fan pulses every 66667 cycles: 300 ticks of the tach clock.
    bus(1'b0, 8'h46, 8'h00);
    fp = got;
    bus(1'b0, 8'h47, 8'h00);
    fp = fp + 256 * got;
    check("tach count", {31'h0, fp >= 299 && fp <= 301}, 32'h1);
    // A one-pulse fan with a 66667-cycle pulse period turns at 18000 per minute.
    check("fan speed", {31'h0, 5400000 / fp >= 17940 && 5400000 / fp <= 18061}, 32'h1);
    tally_and_finish();
  end
  initial
  begin
    repeat (100000) @(posedge ref_clk_i);
    fail_count++;
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
